// File: logic/hfl_load_round_unit.sv
/*
 hex float load and round unit: eight float registers, load, positive
 load, negated load, move to gpr, and a register add that exercises
 equalization, guard digits and rounding. one result per started op that does not fault.
 assumes a classic wishbone master and a sequencer that supplies the
 status-word underflow enable and takes the fault request pulse.
*/
// Decided for this implementation: the Wishbone register port and the placing of the registers.
// How it works
// - shifted-out digits pass through guard digits
// - flag underflow below exponent minus sixty-four
// - enabled underflow: fault, destination untouched
// - disabled underflow: zero result, v flag set
// - guard digits kept, result rounded before write
// - top guard at most seven: truncate
// - guard exactly eight then zeros: force lsb
// - otherwise eight or more: add one ulp
// - rounding carry: bump exponent, fraction 100000
// - eight float registers, even numbers 0-14
// - move to gpr copies into the single gpr word
// - results always normalized
// - loads normalize source into float register
// - load codes: zero, negative, positive, underflow
// - zero fraction loads as all-zero word
// - positive load clears sign before normalizing
// - negated load inverts sign then normalizes
// - sign bit, excess-64 exponent, six digits
// - normalize by hex shifts, exponent down each
module hfl_load_round_unit
   import hfl_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic        uflowEnable,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             faultReq
);

   hfl_state_e  state_r;
   hfl_ctrl_s   ctrl_r;
   logic [31:0] opnd_r;
   logic [31:0] gpr_r;
   logic [31:0] fregs [8];
   logic [3:0]  cc_r;
   logic        lastFault_r;
   logic        ack_r;
   logic [31:0] datO_r;
   logic        faultReq_r;
   logic [31:0] rdData;
   logic        wbWr;
   logic        wbRd;
   logic [2:0]  dIdx;
   logic [2:0]  sIdx;
   logic        isLoad;
   logic        isAdd;
   logic        doCalc;
   logic        fault;
   hfl_word_s   srcW;
   hfl_word_s   dstW;
   hfl_res_s    res;

   assign dat_o    = datO_r;
   assign ack_o    = ack_r;
   assign faultReq = faultReq_r;

   // byte-lane merge for every writable word
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) m[8*b +: 8] = nw[8*b +: 8];
      end
      return m;
   endfunction

   // sign and zero test shared by loads and the move to gpr
   function automatic logic [3:0] ccOf(input hfl_word_s w);
      if (w.frac == 24'h0) return CC_ZERO;
      return w.sgn ? CC_NEG : CC_POS;
   endfunction

   // carry fixup, normalize, then round; m[31:0] are 8 guard digits
   function automatic hfl_res_s normRound(input logic              sgn,
                                          input logic signed [9:0] exIn,
                                          input logic [56:0]       magIn);
      logic [55:0]       m;
      logic signed [9:0] e;
      logic [24:0]       rf;
      hfl_res_s          r;
      r = '0;
      e = exIn;
      m = magIn[55:0];
      if (magIn[56]) begin
         m = {3'h0, magIn[56:4]} | {55'h0, |magIn[3:0]}; // carry back in
         e = e + 10'sd1;
      end
      r.isZero = (m[55:32] == 24'h0) && (m[31:0] == 32'h0);
      // hex shifts keep guard digits moving up into the fraction
      for (int i = 0; i < HFL_NORM_STEPS; i++) begin
         if (!r.isZero && m[55:52] == 4'h0) begin
            m = m << 4;
            e = e - 10'sd1;
         end
      end
      r.gTop  = m[31:28];
      r.gRest = |m[27:0];
      r.tFrac = m[55:32];
      rf = {1'b0, m[55:32]};
      if (r.gTop > 4'h8 || (r.gTop == 4'h8 && r.gRest)) begin
         rf = rf + 25'h1;
      end else if (r.gTop == 4'h8) begin
         rf[0] = 1'b1;
      end
      if (rf[24]) begin
         rf = {1'b0, HFL_FRAC_ONE};
         e  = e + 10'sd1;
      end
      r.uf  = !r.isZero && (e < 10'sd0);
      r.ovf = !r.isZero && (e > 10'sd127);
      // a zero fraction gives the true zero, whatever sign and exponent
      r.word = r.isZero ? hfl_word_s'(HFL_RST_WORD)
                        : {sgn, e[6:0], rf[23:0]};
      return r;
   endfunction

   // odd low bit of a register field is ignored
   assign dIdx = ctrl_r.destField[3:1];
   assign sIdx = ctrl_r.srcField[3:1];
   assign dstW = fregs[dIdx];
   assign isLoad = ctrl_r.opcode inside {OP_LOAD_MEM, OP_LOAD_REG,
                                         OP_LOAD_GPR, OP_LOAD_POS, OP_LOAD_NEG};
   assign isAdd  = (ctrl_r.opcode == OP_ADD_REG);
   assign doCalc = (state_r == ST_EXEC) && (isLoad || isAdd);
   assign fault  = (res.uf && ctrl_r.uflowEn) || res.ovf;

   // operand pick: memory and gpr loads use the operand register
   always_comb begin
      if (ctrl_r.opcode == OP_LOAD_MEM || ctrl_r.opcode == OP_LOAD_GPR) begin
         srcW = hfl_word_s'(opnd_r);
      end else begin
         srcW = hfl_word_s'(fregs[sIdx]);
      end
   end

   // equalize and add, or load path; both finish in normRound
   always_comb begin
      logic [55:0] ma;
      logic [55:0] mb;
      logic [55:0] big;
      logic [55:0] sml;
      logic [55:0] shd;
      logic [56:0] sum;
      logic [6:0]  diff;
      logic [8:0]  sh;
      logic        sBig;
      logic        sSml;
      logic        sRes;
      logic [9:0]  eBig;
      logic        sticky;
      ma = {dstW.frac, 32'h0};
      mb = {srcW.frac, 32'h0};
      sum = 57'h0;
      sRes = 1'b0;
      big    = ma;
      sml    = mb;
      sBig   = dstW.sgn;
      sSml   = srcW.sgn;
      diff   = dstW.ex - srcW.ex;
      eBig   = {3'h0, dstW.ex};
      shd    = 56'h0;
      sticky = 1'b0;
      // the source is the bigger operand only when its exponent is larger
      if (dstW.ex < srcW.ex) begin
         big = mb; sml = ma; sBig = srcW.sgn; sSml = dstW.sgn;
         diff = srcW.ex - dstW.ex;
         eBig = {3'h0, srcW.ex};
      end
      sh = {diff, 2'b00};
      // digits past the datapath still leave a sticky trace
      if (diff >= 7'(HFL_EQ_LIMIT)) begin
         shd    = 56'h0;
         sticky = |sml;
      end else begin
         shd    = sml >> sh;
         sticky = (shd << sh) != sml;
      end
      shd[0] = shd[0] | sticky;
      if (sBig == sSml) begin
         sum  = {1'b0, big} + {1'b0, shd};
         sRes = sBig;
      end else if (big >= shd) begin
         sum  = {1'b0, big - shd};
         sRes = sBig;
      end else begin
         sum  = {1'b0, shd - big};
         sRes = sSml;
      end
      if (isAdd) begin
         res = normRound(sRes, signed'(eBig), sum);
      end else if (ctrl_r.opcode == OP_LOAD_POS) begin
         res = normRound(1'b0, signed'({3'h0, srcW.ex}),
                         {1'b0, mb});
      end else if (ctrl_r.opcode == OP_LOAD_NEG) begin
         res = normRound(~srcW.sgn, signed'({3'h0, srcW.ex}),
                         {1'b0, mb});
      end else begin
         res = normRound(srcW.sgn, signed'({3'h0, srcW.ex}),
                         {1'b0, mb});
      end
   end

   // wishbone strobes; one access per handshake
   assign wbWr = cyc_i && stb_i && we_i && !ack_r;
   assign wbRd = cyc_i && stb_i && !we_i && !ack_r;

   // read mux; unmapped addresses read zero
   always_comb begin
      rdData = 32'h0;
      if (adr_i[7:5] == HFL_FREG_OFS[7:5]) begin
         rdData = fregs[adr_i[4:2]];
      end else begin
         case (adr_i[7:2])
            HFL_CTRL_OFS[7:2]: rdData = 32'(ctrl_r);
            HFL_OPND_OFS[7:2]: rdData = opnd_r;
            HFL_GPR_OFS[7:2]:  rdData = gpr_r;
            HFL_STAT_OFS[7:2]: begin
               rdData[HFL_ST_BUSY]        = (state_r == ST_EXEC);
               rdData[HFL_ST_CC +: 4]     = cc_r;
               rdData[HFL_ST_FLT]         = lastFault_r;
            end
            default: rdData = 32'h0;
         endcase
      end
   end

   // ack for one cycle, read data captured with it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r  <= 1'b0;
         datO_r <= 32'h0;
      end else begin
         ack_r  <= cyc_i && stb_i && !ack_r;
         datO_r <= wbRd ? rdData : 32'h0;
      end
   end

   // control and operand registers; the pin enable is caught at start
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= '0;
         opnd_r <= HFL_RST_WORD;
      end else if (wbWr && state_r == ST_IDLE) begin
         if (adr_i[7:2] == HFL_CTRL_OFS[7:2]) begin
            ctrl_r         <= hfl_ctrl_s'(mergeBytes(32'(ctrl_r), dat_i, sel_i));
            ctrl_r.uflowEn <= uflowEnable;
         end
         if (adr_i[7:2] == HFL_OPND_OFS[7:2]) begin
            opnd_r <= mergeBytes(opnd_r, dat_i, sel_i);
         end
      end
   end

   // a control write starts one execute cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: if (wbWr && adr_i[7:2] == HFL_CTRL_OFS[7:2]) state_r <= ST_EXEC;
            ST_EXEC: state_r <= ST_IDLE;
         endcase
      end
   end

   // float registers: software writes when idle, results at execute
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) fregs[i] <= HFL_RST_WORD;
      end else if (doCalc && !fault) begin
         if (res.uf) begin
            fregs[dIdx] <= HFL_RST_WORD;
         end else begin
            fregs[dIdx] <= 32'(res.word);
         end
      end else if (wbWr && state_r == ST_IDLE
                   && adr_i[7:5] == HFL_FREG_OFS[7:5]) begin
         fregs[adr_i[4:2]] <= mergeBytes(fregs[adr_i[4:2]], dat_i, sel_i);
      end
   end

   // condition code, gpr result and fault status
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cc_r        <= CC_ZERO;
         gpr_r       <= HFL_RST_WORD;
         lastFault_r <= 1'b0;
      end else if (state_r == ST_EXEC) begin
         lastFault_r <= doCalc && fault;
         if (doCalc && !fault) begin
            cc_r <= res.uf ? CC_UNDER : ccOf(res.word);
         end else if (ctrl_r.opcode == OP_MOVE_GPR) begin
            gpr_r <= fregs[sIdx];
            cc_r  <= ccOf(hfl_word_s'(fregs[sIdx]));
         end
      end
   end

   // fault request pulse; on a fault only it and the status fault bit change
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         faultReq_r <= 1'b0;
      end else begin
         faultReq_r <= doCalc && fault;
      end
   end

   fault_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && res.uf && ctrl_r.uflowEn |=> faultReq_r && $stable(fregs[dIdx])
      && $stable(cc_r))
      else $error("enabled underflow did not fault cleanly");
   uf_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && res.uf && !ctrl_r.uflowEn |=> fregs[dIdx] == 32'h0
      && cc_r == CC_UNDER && !faultReq_r)
      else $error("disabled underflow result wrong");
   zero_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && isLoad && srcW.frac == 24'h0 |=> fregs[dIdx] == 32'h0 && cc_r == CC_ZERO)
      else $error("zero fraction not loaded as true zero");
   norm_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && !fault && !res.uf && !res.isZero |=> fregs[dIdx][23:20] != 4'h0)
      else $error("written result not normalized");
   trunc_round_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && !fault && !res.uf && res.gTop <= 4'h7 && !res.isZero
      |=> fregs[dIdx][23:0] == $past(res.tFrac))
      else $error("truncation changed the fraction");
   half_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && !fault && !res.uf && res.gTop == 4'h8 && !res.gRest
      |=> fregs[dIdx][23:0] == ($past(res.tFrac) | 24'h1))
      else $error("halfway case did not force lsb");
   up_round_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && !fault && !res.uf && (res.gTop > 4'h8 || (res.gTop == 4'h8 && res.gRest))
      |=> fregs[dIdx][23:0] == (&$past(res.tFrac) ? HFL_FRAC_ONE : $past(res.tFrac) + 24'h1))
      else $error("round up wrong");
   pos_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && !fault && ctrl_r.opcode == OP_LOAD_POS |=> !fregs[dIdx][31] && cc_r != CC_NEG)
      else $error("positive load left a negative");
   neg_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doCalc && !fault && !res.uf && ctrl_r.opcode == OP_LOAD_NEG && srcW.frac != 24'h0
      |=> fregs[dIdx][31] != $past(srcW.sgn))
      else $error("negated load kept the sign");
   gpr_move_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == ST_EXEC && ctrl_r.opcode == OP_MOVE_GPR
      |=> gpr_r == $past(fregs[sIdx]) && $stable(fregs[dIdx]))
      else $error("move to gpr wrong");
   ack_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ack_r |=> !ack_r)
      else $error("ack held more than one cycle");
endmodule

// File: logic/hfl_pkg.sv
/*
 package for the hex float load and round unit: register map, control
 fields, opcodes, condition codes and the structs the datapath passes.
 assumes a 32-bit classic wishbone slave with byte addresses.
*/
package hfl_pkg;
   // register byte offsets
   localparam logic [7:0] HFL_CTRL_OFS = 8'h00; // op start
   localparam logic [7:0] HFL_OPND_OFS = 8'h04; // memory or gpr operand
   localparam logic [7:0] HFL_STAT_OFS = 8'h08;
   localparam logic [7:0] HFL_GPR_OFS  = 8'h0c; // move-to-gpr result
   localparam logic [7:0] HFL_FREG_OFS = 8'h20; // 8 float regs, one word each
   // status field positions
   localparam int HFL_ST_BUSY = 0;
   localparam int HFL_ST_CC   = 4;
   localparam int HFL_ST_FLT  = 8;
   localparam logic [31:0] HFL_RST_WORD = 32'h0000_0000;
   localparam logic [23:0] HFL_FRAC_ONE = 24'h10_0000;
   localparam int HFL_NORM_STEPS = 13;  // 14 digits, lead nonzero after 13
   localparam int HFL_EQ_LIMIT   = 14;  // gap that empties the datapath
   // opcodes
   localparam logic [7:0] OP_LOAD_MEM  = 8'h68; // load_float_memory
   localparam logic [7:0] OP_LOAD_REG  = 8'h28; // load_float_reg_copy
   localparam logic [7:0] OP_LOAD_GPR  = 8'ha5; // load_float_from_gpr
   localparam logic [7:0] OP_LOAD_POS  = 8'h13; // load_positive_float
   localparam logic [7:0] OP_LOAD_NEG  = 8'h17; // load_negated_float
   localparam logic [7:0] OP_MOVE_GPR  = 8'h15; // move_float_to_gpr
   localparam logic [7:0] OP_ADD_REG   = 8'h2a; // register add
   // condition codes, bit order c v g l
   localparam logic [3:0] CC_ZERO  = 4'h0;
   localparam logic [3:0] CC_NEG   = 4'h1;
   localparam logic [3:0] CC_POS   = 4'h2;
   localparam logic [3:0] CC_UNDER = 4'h4;

   typedef struct packed {
      logic        sgn;
      logic [6:0]  ex;    // excess-64
      logic [23:0] frac;  // six hex digits
   } hfl_word_s;

   typedef struct packed {
      logic        uflowEn;
      logic [3:0]  srcField;
      logic [3:0]  destField;
      logic [7:0]  opcode;
   } hfl_ctrl_s;

   typedef struct packed {
      hfl_word_s   word;
      logic        uf;
      logic        ovf;
      logic        isZero;
      logic [3:0]  gTop;
      logic        gRest;
      logic [23:0] tFrac;
   } hfl_res_s;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } hfl_state_e;
endpackage

// File: dv/hfl_seq_model.sv
/*
 sequencer model: holds the status-word underflow enable and counts the
 fault request pulses that the unit raises.
 assumes one clock and an async active-low reset shared with the unit.
*/
module hfl_seq_model
   import hfl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       faultReq,
   input  wire logic       wantEnable,
   output logic            uflowEnable,
   output logic      [7:0] faultCount
);
   timeunit 1ns;
   timeprecision 1ps;

   // enable moves only after an edge, like a status word updated by an instruction
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         uflowEnable <= 1'b0;
         faultCount  <= 8'h00;
      end else begin
         uflowEnable <= wantEnable;
         if (faultReq) begin
            faultCount <= faultCount + 8'h01; // a pulse held two cycles counts twice
         end
      end
   end
endmodule

// File: dv/test_hfl_load_round_unit.sv
/*
 self-checking bench for the hex float load and round unit: wishbone
 tasks, a read monitor fed by a queue of expected words, rounding table.
 assumes the one-cycle ack and the two-edge commit of a started op.
*/
module test_hfl_load_round_unit;
   import hfl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk, rst_n, cyc, stb, we, wantEn, uEn, faultReq, ack;
   logic [7:0]  adr, faultCount;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [31:0] expQ[$];
   int          mismatches, n_tests, seed, i;
   logic [35:0] nr;
   logic [31:0] opnd;
   logic [31:0] addTab[6][3];

   hfl_load_round_unit u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .uflowEnable(uEn),
      .dat_o(rdat), .ack_o(ack), .faultReq(faultReq));

   hfl_seq_model u_seq (
      .ref_clk(ref_clk), .rst_n(rst_n), .faultReq(faultReq),
      .wantEnable(wantEn), .uflowEnable(uEn), .faultCount(faultCount));

   // clock at 20 mhz
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one classic cycle; the idle cycle comes from the edge awaited on entry
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge ref_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (ack === 1'b1) break;
      end
      if (n == 20) begin
         mismatches++;
         print_verdict();
      end
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask

   task automatic op(input logic [7:0] opc, input logic [3:0] dst, input logic [3:0] src);
      wb(1'b1, HFL_CTRL_OFS, {16'h0, src, dst, opc}, 4'hf);
   endtask

   // float register by index, then the status word with busy low
   task automatic chk(input logic [2:0] k, input logic [31:0] w, input logic [3:0] cc,
                      input logic flt);
      rd(HFL_FREG_OFS + {3'h0, k, 2'b00}, w);
      rd(HFL_STAT_OFS, {23'h0, flt, cc, 4'h0});
   endtask

   // reference normalizer: hex shifts with exponent down, zero and underflow cases
   function automatic logic [35:0] norm(input logic [31:0] w);
      logic [23:0] f;
      int          ex;
      f  = w[23:0];
      ex = int'(w[30:24]);
      if (f == 24'h0) return {CC_ZERO, 32'h0};
      for (int s = 0; s < 6; s++) begin
         if (f[23:20] == 4'h0) begin
            f  = f << 4;
            ex = ex - 1;
         end
      end
      if (ex < 0) return {CC_UNDER, 32'h0};
      return {(w[31] ? CC_NEG : CC_POS), w[31], 7'(ex), f};
   endfunction

   // read monitor: compare at the ack edge against the oldest expectation
   always @(posedge ref_clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (expQ.size() == 0) begin
            // a read nobody asked for is an error whatever it returns
            n_tests++;
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, rdat, 32'h0);
         end else begin
            cmp(rdat, expQ.pop_front());
         end
      end
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      addTab = '{'{32'h43123456, 32'h3f789abc, 32'h431234cf},
                 '{32'h41100000, 32'h3b700000, 32'h41100000},
                 '{32'h41100000, 32'h3b800000, 32'h41100001},
                 '{32'h41100001, 32'h3b810000, 32'h41100002},
                 '{32'h41ffffff, 32'h3bf00000, 32'h42100000},
                 '{32'h41100000, 32'h3a800000, 32'h41100000}};
      seed = 14;
      mismatches = 0; n_tests = 0;
      cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
      wantEn = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      // reset contents, refused writes and an unmapped place
      chk(3'h0, HFL_RST_WORD, CC_ZERO, 1'b0);
      rd(HFL_GPR_OFS, 32'h0);
      wb(1'b1, HFL_STAT_OFS, 32'hffff_ffff, 4'hf);
      wb(1'b1, 8'h10, 32'h1234_5678, 4'hf);
      rd(8'h10, 32'h0);
      rd(HFL_STAT_OFS, 32'h0);
      // directed loads into odd fields, which select the even register below
      for (i = 0; i < 6; i++) begin
         opnd = (i == 0) ? 32'h42001000 : (i == 1) ? 32'hc900fe12 : (i == 2) ? 32'h6c000000 :
                (i == 3) ? 32'h21000abc : (i == 4) ? 32'h80000000 : 32'h00000001;
         nr = norm(opnd);
         wb(1'b1, HFL_OPND_OFS, opnd, 4'hf);
         op(i[0] ? OP_LOAD_GPR : OP_LOAD_MEM, {i[2:0], 1'b1}, 4'h0);
         chk(i[2:0], nr[31:0], nr[35:32], 1'b0);
      end
      // random operands, underflow disabled
      for (i = 0; i < 10; i++) begin
         opnd = $random(seed);
         nr = norm(opnd);
         wb(1'b1, HFL_OPND_OFS, opnd, 4'hf);
         op(OP_LOAD_MEM, {opnd[26:24], 1'b0}, 4'h0);
         chk(opnd[26:24], nr[31:0], nr[35:32], 1'b0);
      end
      // byte enables merge into the operand
      wb(1'b1, HFL_OPND_OFS, 32'h1111_1111, 4'hf);
      wb(1'b1, HFL_OPND_OFS, 32'h4200_0000, 4'hc);
      op(OP_LOAD_MEM, 4'h2, 4'h0);
      chk(3'h1, 32'h4011_1100, CC_POS, 1'b0);
      // enabled underflow leaves register and code as they were
      wb(1'b1, HFL_OPND_OFS, 32'h4112_3456, 4'hf);
      op(OP_LOAD_MEM, 4'h6, 4'h0);
      wantEn <= 1'b1;
      wb(1'b1, HFL_OPND_OFS, 32'h0000_0001, 4'hf);
      op(OP_LOAD_MEM, 4'h6, 4'h0);
      chk(3'h3, 32'h4112_3456, CC_POS, 1'b1);
      cmp({24'h0, faultCount}, 32'h1);
      wantEn <= 1'b0;
      // register loads: positive, negated, copy, move to general register
      wb(1'b1, HFL_OPND_OFS, 32'hc119_21fb, 4'hf);
      op(OP_LOAD_MEM, 4'h8, 4'h0);
      op(OP_LOAD_POS, 4'ha, 4'h8);
      chk(3'h5, 32'h4119_21fb, CC_POS, 1'b0);
      op(OP_LOAD_NEG, 4'hc, 4'ha);
      chk(3'h6, 32'hc119_21fb, CC_NEG, 1'b0);
      // negating a zero fraction must still give the all-zero word
      wb(1'b1, HFL_OPND_OFS, 32'h4000_0000, 4'hf);
      op(OP_LOAD_MEM, 4'he, 4'h0);
      op(OP_LOAD_NEG, 4'he, 4'he);
      chk(3'h7, 32'h0, CC_ZERO, 1'b0);
      op(OP_LOAD_REG, 4'he, 4'h8);
      chk(3'h7, 32'hc119_21fb, CC_NEG, 1'b0);
      op(OP_MOVE_GPR, 4'h3, 4'hc);
      rd(HFL_GPR_OFS, 32'hc119_21fb);
      chk(3'h1, 32'h4011_1100, CC_NEG, 1'b0);
      // add through guard digits and each rounding case
      for (i = 0; i < 6; i++) begin
         wb(1'b1, HFL_OPND_OFS, addTab[i][0], 4'hf);
         op(OP_LOAD_MEM, 4'h2, 4'h0);
         wb(1'b1, HFL_OPND_OFS, addTab[i][1], 4'hf);
         op(OP_LOAD_MEM, 4'h4, 4'h0);
         op(OP_ADD_REG, 4'h2, 4'h4);
         chk(3'h1, addTab[i][2], CC_POS, 1'b0);
      end
      cmp({24'h0, faultCount}, 32'h1);
      // exponent overflow on the add faults and leaves register and code alone
      wb(1'b1, HFL_OPND_OFS, 32'h7fff_ffff, 4'hf);
      op(OP_LOAD_MEM, 4'h2, 4'h0);
      op(OP_LOAD_MEM, 4'h4, 4'h0);
      op(OP_ADD_REG, 4'h2, 4'h4);
      chk(3'h1, 32'h7fff_ffff, CC_POS, 1'b1);
      cmp({24'h0, faultCount}, 32'h2);
      repeat (3) @(posedge ref_clk);
      cmp(expQ.size(), 32'h0);
      print_verdict();
   end
endmodule
